//--- spi_chain_pkg.sv
// Shared constants, types and state records of the daisy-chain serial port.
package spi_chain_pkg;

    // Frame and field geometry.
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned IDX_W      = 3;
    localparam int unsigned REG_COUNT  = 8;
    localparam int unsigned OP_HI      = 15;
    localparam int unsigned OP_LO      = 14;
    localparam int unsigned ADDR_HI    = 11;
    localparam int unsigned ADDR_LO    = 8;
    localparam int unsigned DATA_HI    = 7;
    localparam int unsigned DATA_LO    = 0;

    // Bit counter marks: sixteenth falling edge, then steps of eight.
    localparam logic [3:0] CNT_FIRST  = 4'h1;
    localparam logic [3:0] CNT_LAST16 = 4'hF;
    localparam logic [2:0] STEP_ZERO  = 3'h0;
    localparam logic [2:0] STEP_ONE   = 3'h1;

    // Command leading bits and register limit.
    localparam logic [1:0]        OP_WRITE  = 2'h2;
    localparam logic [1:0]        OP_READ   = 2'h1;
    localparam logic [ADDR_W-1:0] REG_LIMIT = 4'h8;

    // Response word: flag bit, then tag, address and data.
    localparam logic [2:0]  TAG_WRITE     = 3'h1;
    localparam logic [2:0]  TAG_READ      = 3'h2;
    localparam logic [14:0] BODY_RESET    = 15'h7001;
    localparam logic [14:0] BODY_TX_ERROR = 15'h7002;
    localparam logic [14:0] BODY_SYNTAX   = 15'h7003;
    localparam logic [15:0] RESP_RESET    = {1'b0, BODY_RESET};

    // States of the frame tracker in the system domain.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_ACTIVE  = 3'b010,
        ST_BLOCKED = 3'b100
    } port_state_e;

    typedef logic [REG_COUNT-1:0][DATA_W-1:0] reg_file_t;

    // Serial-clock state, updated on falling edges.
    typedef struct packed {
        logic                  ge16;
        logic [3:0]            cnt;
        logic [FRAME_BITS-1:0] shift;
        logic                  first_tog;
    } link_state_s;

    // System-clock state.
    typedef struct packed {
        port_state_e           state;
        logic                  err_flag;
        logic [FRAME_BITS-1:0] resp;
        logic                  oe;
        logic                  wr_pulse;
        logic                  seen_tog;
        reg_file_t             regs;
    } sys_state_s;

    localparam link_state_s LINK_RESET = '{ge16: 1'b0, cnt: 4'h0, shift: 16'h0000,
                                           first_tog: 1'b0};
    localparam sys_state_s  SYS_RESET  = '{state: ST_IDLE, err_flag: 1'b0, resp: RESP_RESET,
                                           oe: 1'b0, wr_pulse: 1'b0, seen_tog: 1'b0,
                                           regs: '0};

endpackage

//--- level_sync.sv
// Two-stage synchroniser for one level into the system clock domain.
`timescale 1ns/1ns
module level_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Level in and synchronised level out.
    input  wire logic async_in,
    output logic      sync_out
);

    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    // The first stage feeds only the second.
    always_comb begin
        stage_next = {stage_reg[0], async_in};
    end

    // Both stages take the reset constant.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign sync_out = stage_reg[1];

endmodule

//--- spi_chain_port.sv
// Serial slave port with daisy-chain frame checks and a small register file.
`timescale 1ns/1ns
module spi_chain_port (
    // System clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // Serial link pins.
    input  wire logic                 spi_clk,
    input  wire logic                 chip_select_n,
    input  wire logic                 serial_in,
    output logic                      serial_out,
    output logic                      serial_out_oe,
    // Device side.
    input  wire logic                 sleep_mode,
    output spi_chain_pkg::reg_file_t  reg_file_out,
    output logic                      reg_write_pulse,
    output logic                      transmission_error_flag
);
    import spi_chain_pkg::*;

    // Link-domain state.
    link_state_s link_reg;
    link_state_s link_next;
    logic        started_reg;
    logic        rose_reg;
    logic        so_bit_reg;
    logic        link_clear;

    // System-domain state and decode helpers.
    sys_state_s              sys_reg;
    sys_state_s              sys_next;
    logic                    cs_s;
    logic                    sleep_s;
    logic                    tog_s;
    logic                    frame_end;
    logic                    had_edges;
    logic                    frame_ok;
    logic                    addr_ok;
    logic [1:0]              cmd_op;
    logic [ADDR_W-1:0]       cmd_addr;
    logic [IDX_W-1:0]        cmd_idx;
    logic [DATA_W-1:0]       cmd_data;

    // The frame-start flag and output stage are cleared while the port is not selected.
    assign link_clear = sys_rst | chip_select_n;

    // restart per access
    // The frame-start flag drops whenever select is high, so the next
    // falling clock edge knows it is the first one of a new access.
    always_ff @(negedge spi_clk or posedge link_clear) begin
        if (link_clear) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Falling-edge shift and bit counting.
    always_comb begin
        link_next = link_reg;
        if (!chip_select_n) begin
            if (!started_reg) begin
                // load pending response
                // The pending answer stands in the shift register ahead of
                // the first input bit, which enters at the bottom.
                link_next.shift     = {sys_reg.resp[FRAME_BITS-2:0], serial_in};
                link_next.cnt       = CNT_FIRST;
                link_next.ge16      = 1'b0;
                link_next.first_tog = ~link_reg.first_tog;
            end else begin
                link_next.shift = {link_reg.shift[FRAME_BITS-2:0], serial_in};
                if (!link_reg.ge16) begin
                    if (link_reg.cnt == CNT_LAST16) begin
                        link_next.ge16 = 1'b1;
                        link_next.cnt  = 4'h0;
                    end else begin
                        link_next.cnt = link_reg.cnt + CNT_FIRST;
                    end
                end else begin
                    link_next.cnt = {1'b0, link_reg.cnt[2:0] + STEP_ONE};
                end
            end
        end
    end

    // capture on falling edge
    // Count and word are kept after select rises so that the system side
    // can judge the frame; they are not cleared by select.
    always_ff @(negedge spi_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_reg <= LINK_RESET;
        end else begin
            link_reg <= link_next;
        end
    end

    // MSB first output
    // Each rising edge presents the top of the shift register; before the
    // first falling edge that is still the pending response word.
    always_ff @(posedge spi_clk or posedge link_clear) begin
        if (link_clear) begin
            rose_reg   <= 1'b0;
            so_bit_reg <= 1'b0;
        end else begin
            rose_reg   <= 1'b1;
            so_bit_reg <= started_reg ? link_reg.shift[FRAME_BITS-1]
                                      : sys_reg.resp[FRAME_BITS-1];
        end
    end

    // flag OR input
    // Until the first rising edge the output lets a chained error through.
    assign serial_out = rose_reg ? so_bit_reg : (sys_reg.err_flag | serial_in);

    // Select, sleep and frame toggle into the system domain.
    level_sync #(
        .RESET_VAL (1'b1)
    ) u_cs_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (chip_select_n),
        .sync_out (cs_s)
    );

    level_sync #(
        .RESET_VAL (1'b0)
    ) u_sleep_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (sleep_mode),
        .sync_out (sleep_s)
    );

    level_sync #(
        .RESET_VAL (1'b0)
    ) u_tog_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (link_reg.first_tog),
        .sync_out (tog_s)
    );

    // control then data
    // Command fields sit in the last sixteen bits shifted in.
    assign cmd_op   = link_reg.shift[OP_HI:OP_LO];
    assign cmd_addr = link_reg.shift[ADDR_HI:ADDR_LO];
    assign cmd_idx  = cmd_addr[IDX_W-1:0];
    assign cmd_data = link_reg.shift[DATA_HI:DATA_LO];
    assign addr_ok  = cmd_addr < REG_LIMIT;

    // clock low at select edges
    // The link word is read only after select is seen high through the
    // synchroniser; by then no clock edge can move it.
    assign frame_end = (sys_reg.state == ST_ACTIVE) && cs_s;
    assign had_edges = tog_s != sys_reg.seen_tog;

    assign frame_ok  = had_edges && link_reg.ge16 && (link_reg.cnt[2:0] == STEP_ZERO);

    // Frame tracking, decode and response preparation.
    always_comb begin
        sys_next          = sys_reg;
        sys_next.wr_pulse = 1'b0;
        unique case (sys_reg.state)
            ST_IDLE: begin
                if (!cs_s) begin
                    if (sleep_s) begin
                        sys_next.state = ST_BLOCKED;
                    end else begin
                        sys_next.state = ST_ACTIVE;
                        sys_next.oe    = 1'b1;
                    end
                end
            end
            ST_ACTIVE: begin
                if (cs_s) begin
                    sys_next.state    = ST_IDLE;
                    sys_next.oe       = 1'b0;
                    sys_next.seen_tog = tog_s;
                    if (!frame_ok) begin
                        sys_next.err_flag = 1'b1;
                        sys_next.resp     = {1'b1, BODY_TX_ERROR};
                    end else begin
                        // clear once reported
                        // A set flag went out at the head of this frame.
                        sys_next.err_flag = 1'b0;
                        if ((cmd_op == OP_WRITE) && addr_ok) begin
                            sys_next.regs[cmd_idx] = cmd_data;
                            sys_next.wr_pulse      = 1'b1;
                            sys_next.resp = {1'b0, TAG_WRITE, cmd_addr, cmd_data};
                        end else if ((cmd_op == OP_READ) && addr_ok) begin
                            sys_next.resp = {1'b0, TAG_READ, cmd_addr,
                                             sys_reg.regs[cmd_idx]};
                        end else begin
                            sys_next.resp = {1'b0, BODY_SYNTAX};
                        end
                    end
                end
            end
            ST_BLOCKED: begin
                if (cs_s) begin
                    sys_next.state    = ST_IDLE;
                    sys_next.seen_tog = tog_s;
                end
            end
        endcase
    end

    // System-domain state register.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_reg <= SYS_RESET;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // Outputs straight from state flip-flops.
    assign serial_out_oe           = sys_reg.oe;
    assign reg_file_out            = sys_reg.regs;
    assign reg_write_pulse         = sys_reg.wr_pulse;
    assign transmission_error_flag = sys_reg.err_flag;

    // Output released while select stays high.
    oe_idle_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cs_s && $past(cs_s)) |-> !serial_out_oe
    ) else $error("serial output driven while deselected");

    // Output enabled after an awake select fall.
    oe_frame_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_reg.state == ST_IDLE && !cs_s && !sleep_s) |=> serial_out_oe
    ) else $error("serial output not enabled in frame");

    // Output stays released during a sleep frame.
    sleep_oe_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_reg.state == ST_BLOCKED) |-> !serial_out_oe
    ) else $error("serial output driven in sleep");

    // A sleep frame changes no register.
    sleep_nowr_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (sys_reg.state == ST_BLOCKED && cs_s) |=> !reg_write_pulse && $stable(reg_file_out)
    ) else $error("sleep frame wrote a register");

    // A bad length raises the flag and keeps the registers.
    flag_set_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && !frame_ok) |=> transmission_error_flag && $stable(reg_file_out)
    ) else $error("bad frame length not flagged");

    // The answer after a length error is the special frame.
    error_resp_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && !frame_ok) |=> sys_reg.resp == {1'b1, BODY_TX_ERROR}
    ) else $error("wrong answer after transmission error");

    // A valid write lands in the addressed register.
    write_ok_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && frame_ok && cmd_op == OP_WRITE && addr_ok)
        |=> reg_write_pulse && (reg_file_out[$past(cmd_idx)] == $past(cmd_data))
    ) else $error("valid write not stored");

    // Bad leading bits or unused addresses answer with the syntax frame.
    syntax_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && frame_ok && !((cmd_op == OP_WRITE || cmd_op == OP_READ) && addr_ok))
        |=> (sys_reg.resp == {1'b0, BODY_SYNTAX}) && $stable(reg_file_out)
    ) else $error("syntax error not answered");

    // A read is answered with the register in the next transfer.
    read_next_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && frame_ok && cmd_op == OP_READ && addr_ok)
        |=> sys_reg.resp == {1'b0, TAG_READ, $past(cmd_addr), $past(sys_reg.regs[cmd_idx])}
    ) else $error("read answer wrong");

    // The flag clears after a good frame that reported it.
    flag_clear_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (frame_end && frame_ok) |=> !transmission_error_flag
    ) else $error("error flag not cleared");

    // The flag holds between frame ends.
    flag_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (transmission_error_flag && !frame_end) |=> transmission_error_flag
    ) else $error("error flag lost before report");

    // The first falling edge loads the pending answer above the new bit.
    load_resp_a: assert property (
        @(negedge spi_clk) disable iff (sys_rst)
        (!chip_select_n && !started_reg)
        |=> link_reg.shift[FRAME_BITS-1:1] == $past(sys_reg.resp[FRAME_BITS-2:0])
    ) else $error("response not loaded at frame start");

    // Main scenarios.
    write_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        frame_end && frame_ok && cmd_op == OP_WRITE && addr_ok
    );
    read_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        frame_end && frame_ok && cmd_op == OP_READ && addr_ok
    );
    txerr_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        frame_end && !frame_ok
    );
    sleep_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        sys_reg.state == ST_BLOCKED && cs_s
    );

endmodule

//--- spi_master_model.sv
// Bus master model that frames serial transfers towards the port.
`timescale 1ns/1ns
module spi_master_model (
    // Serial link pins driven towards the port.
    output logic      spi_clk,
    output logic      chip_select_n,
    output logic      serial_in,
    // Serial output seen from the port.
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    logic so_last;
    logic so_seen;

    // A released output line shows the inverse of its last driven value.
    initial so_last = 1'b0;
    always @(serial_out or serial_out_oe) begin
        if (serial_out_oe === 1'b1) so_last = serial_out;
    end
    assign so_seen = (serial_out_oe === 1'b1) ? serial_out : ~so_last;

    // The link is quiet until a frame starts.
    initial begin
        spi_clk       = 1'b0;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
    end

    // One framed transfer of nbits; pre is the output before the first edge.
    task automatic xfer(input int nbits, input logic [31:0] tx, output logic pre,
                        output logic [31:0] rx);
        rx = '0;
        serial_in = (nbits > 0) ? tx[nbits-1] : 1'b0;
        #20;
        chip_select_n = 1'b0;
        #240;
        pre = so_seen;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_clk = 1'b1;
            #4;
            serial_in = tx[i];
            #12;
            rx[i] = so_seen;
            spi_clk = 1'b0;
            #16;
        end
        #240;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
        #400;
    endtask

    // Clock pulses while the port is not selected.
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            spi_clk = 1'b1;
            #16;
            spi_clk = 1'b0;
            #16;
        end
    endtask
endmodule

//--- spi_slave_daisy_chain_port_test.sv
// Self-checking testbench for the daisy-chain serial port.
`timescale 1ns/1ns
module spi_slave_daisy_chain_port_test;
    import spi_chain_pkg::*;

    logic        sys_clk;
    logic        sys_rst;
    logic        sleep_mode;
    logic        spi_clk;
    logic        chip_select_n;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe;
    reg_file_t   reg_file_out;
    reg_file_t   snap;
    logic        reg_write_pulse;
    logic        transmission_error_flag;
    logic        pre;
    logic [31:0] rx;
    logic        oe_seen;
    int          err_total;
    int          checks;
    int          cycles;
    int          pulses;

    // System clock at 100 MHz.
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    spi_chain_port u_dut (
        .sys_clk                 (sys_clk),
        .sys_rst                 (sys_rst),
        .spi_clk                 (spi_clk),
        .chip_select_n           (chip_select_n),
        .serial_in               (serial_in),
        .serial_out              (serial_out),
        .serial_out_oe           (serial_out_oe),
        .sleep_mode              (sleep_mode),
        .reg_file_out            (reg_file_out),
        .reg_write_pulse         (reg_write_pulse),
        .transmission_error_flag (transmission_error_flag)
    );

    spi_master_model u_master (
        .spi_clk       (spi_clk),
        .chip_select_n (chip_select_n),
        .serial_in     (serial_in),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe)
    );

    // Counts cycles and write pulses, notes output enables; cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (reg_write_pulse === 1'b1) pulses++;
        if (serial_out_oe === 1'b1) oe_seen = 1'b1;
        if (cycles == 30000) begin
            err_total++;
            test_done();
        end
    end

    // Compares one value and reports a difference.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Starts one frame just after a system clock edge.
    task automatic frame(input int nbits, input logic [31:0] tx);
        @(posedge sys_clk);
        #1;
        oe_seen = 1'b0;
        u_master.xfer(nbits, tx, pre, rx);
    endtask

    // Reset values, then the reset answer in the first frame.
    task automatic reset_values();
        check("oe", 32'(serial_out_oe), 32'h0);
        check("flag", 32'(transmission_error_flag), 32'h0);
        check("regs", 32'(reg_file_out == '0), 32'h1);
        repeat (3) @(posedge sys_clk);
        frame(16, 32'h0000_4000);
        check("pre", 32'(pre), 32'h0);
        check("oe_seen", 32'(oe_seen), 32'h1);
        check("resp", rx, {16'h0, RESP_RESET});
        check("oe_off", 32'(serial_out_oe), 32'h0);
    endtask

    // 24-clock write, pass-through, answers one frame late.
    task automatic write_then_read();
        frame(24, 32'h00C6_8355);
        check("rx24", rx, 32'h0020_00C6);
        check("reg3", 32'(reg_file_out[3]), 32'h55);
        check("pulses", 32'(pulses), 32'h1);
        frame(16, 32'h0000_4300);
        check("wr_resp", rx, {16'h0, 1'b0, TAG_WRITE, 4'h3, 8'h55});
        frame(16, 32'h0000_4000);
        check("rd_resp", rx, {16'h0, 1'b0, TAG_READ, 4'h3, 8'h55});
        check("pulses", 32'(pulses), 32'h1);
    endtask

    // Wrong clock counts set the flag; a good frame reports and clears it.
    task automatic tx_errors();
        int bad[6] = '{0, 8, 15, 17, 20, 23};
        foreach (bad[i]) begin
            frame(bad[i], 32'h0000_8711);
            check("flag_set", 32'(transmission_error_flag), 32'h1);
            check("reg7", 32'(reg_file_out[7]), 32'h0);
            check("pulses", 32'(pulses), 32'h1);
            frame(16, 32'h0000_4000);
            check("pre_err", 32'(pre), 32'h1);
            check("err_resp", rx, {16'h0, 1'b1, BODY_TX_ERROR});
            check("flag_clr", 32'(transmission_error_flag), 32'h0);
        end
    endtask

    // Bad leading bits and unused registers give the syntax answer.
    task automatic syntax_errors();
        logic [15:0] cmd[4] = '{16'hC355, 16'h0355, 16'h8855, 16'h4F00};
        snap = reg_file_out;
        foreach (cmd[i]) begin
            frame(16, {16'h0, cmd[i]});
            check("pre_si", 32'(pre), 32'(cmd[i][15]));
            check("regs_kept", 32'(reg_file_out == snap), 32'h1);
            frame(16, 32'h0000_4000);
            check("syn_resp", rx, {16'h0, 1'b0, BODY_SYNTAX});
        end
        check("pulses", 32'(pulses), 32'h1);
    endtask

    // Sleep keeps the output released; stray clocks are ignored.
    task automatic sleep_and_stray();
        @(posedge sys_clk);
        #1;
        sleep_mode = 1'b1;
        repeat (4) @(posedge sys_clk);
        frame(16, 32'h0000_8122);
        check("sleep_oe", 32'(oe_seen), 32'h0);
        check("reg1", 32'(reg_file_out[1]), 32'h0);
        @(posedge sys_clk);
        #1;
        sleep_mode = 1'b0;
        oe_seen    = 1'b0;
        repeat (4) @(posedge sys_clk);
        u_master.stray_clocks(20);
        check("stray_oe", 32'(oe_seen), 32'h0);
        frame(16, 32'h0000_4000);
        check("kept_resp", rx, {16'h0, 1'b0, TAG_READ, 12'h000});
        check("count_restart", 32'(transmission_error_flag), 32'h0);
    endtask

    // Main sequence.
    initial begin
        sys_rst    = 1'b1;
        sleep_mode = 1'b0;
        err_total  = 0;
        checks     = 0;
        cycles     = 0;
        pulses     = 0;
        oe_seen    = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        reset_values();
        write_then_read();
        tx_errors();
        syntax_errors();
        sleep_and_stray();
        test_done();
    end
endmodule
